/* File: rtl/nv_array_ctrl.v */
// program/erase controller for the 512-byte nonvolatile array, avalon-mm slave
//
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`include "nv_array_consts.vh"
`default_nettype none
module nv_array_ctrl #(
	parameter FALL_CYC = 4 // high voltage decay model, cycles
) (
	input wire clk_sys_i, // system clock, 40 mhz
	input wire rst_i, // synchronous reset, active high
	input wire [11:0] avs_address_i, // byte address
	input wire avs_read_i, // read strobe
	input wire avs_write_i, // write strobe
	input wire [31:0] avs_writedata_i, // write data, low byte used
	input wire [3:0] avs_byteenable_i, // byte enables, lane 0 used
	output reg [31:0] avs_readdata_o, // read data
	output wire avs_waitrequest_o, // wait request
	output wire [1:0] avs_response_o, // 00 okay, 10 slave error
	output wire pump_on_o, // charge pump running
	output wire hv_present_o, // high voltage on the array
	output wire [7:0] config_o // volatile configuration to the chip
);
	// bus view: one wait cycle on every request; a write acts on the edge
	// at which wait is still high, and the answer follows one cycle later
	// map: array at 0x800-0x9ff, config byte 0xe1c, control 0xe1d,
	// volatile config 0xe1f; anything else answers with a slave error
	// software times the program, erase and fall waits; the block only
	// enforces the step order and the block protection
	// control register fields
	reg pgm_r; // program enable
	reg lat_r; // bus latch
	reg [1:0] ras_r; // erase select
	reg off_r; // power down flag, stored only
	reg bclk_r; // pump clock select, stored only
	reg [7:0] vcfg_r; // volatile array configuration
	reg [8:0] lat_addr_r; // captured array address
	reg [7:0] lat_data_r; // captured data
	reg lat_nv_r; // captured target is config byte
	reg captured_r; // a valid write has been captured
	reg nonarray_wr_r; // unlatched non-array write seen
	reg [7:0] nvcfg_r; // nonvolatile config cell
	reg ack_r; // answer phase for the current request
	reg [1:0] resp_r; // response of the answer
	reg reload_r; // config reload pending
	reg pgm_d_r; // enable delayed for edge detect
	// next values of the sequencing state
	reg pgm_nxt; // program enable next
	reg lat_nxt; // bus latch next
	reg [1:0] ras_nxt; // erase select next
	reg captured_nxt; // capture flag next
	reg nonarray_wr_nxt; // non-array write flag next
	reg [7:0] rd_mux; // read byte before its flop
	// decoded request
	wire req = (avs_read_i | avs_write_i) & ~ack_r;
	wire in_array = avs_address_i >= `ARRAY_BASE_IDX && avs_address_i <= `ARRAY_LAST_IDX;
	wire is_nv = avs_address_i == `NVCFG_IDX;
	wire is_ctrl = avs_address_i == `CTRL_IDX;
	wire is_vcfg = avs_address_i == `VCFG_IDX;
	wire mapped = in_array | is_nv | is_ctrl | is_vcfg;
	wire lane0 = avs_byteenable_i[0];
	wire [7:0] wbyte = avs_writedata_i[7:0];
	wire [8:0] arr_addr = avs_address_i[8:0];
	wire [7:0] ctrl_val = {bclk_r, 1'b0, off_r, ras_r, lat_r, 1'b0, pgm_r};
	wire [7:0] arr_rdata; // array cell at the bus address
	// write classes, decided in the first cycle of a request
	wire wr_now = req & avs_write_i & lane0; // write that acts this cycle
	wire cap_wr = wr_now & (in_array | is_nv) & lat_r;
	wire ctrl_wr = wr_now & is_ctrl & (~lat_r | captured_r);
	wire stray_wr = wr_now & ~in_array & ~is_ctrl & ~lat_r;
	// protection of the latched block; one bit per 128-byte block
	wire [3:0] prot = vcfg_r[3:0];
	wire blk_prot = prot[lat_addr_r[8:7]];
	wire any_prot = |prot;
	// operation fires on the rising edge of program enable
	wire pgm_rise = pgm_r & ~pgm_d_r;
	wire go = pgm_rise & lat_r & captured_r; // latched, captured and just enabled
	reg do_prog; // byte program into the array
	reg do_nv_prog; // program of the config byte
	reg do_byte_er; // byte erase in the array
	reg do_nv_er; // erase of the config byte
	reg do_blk_er; // block erase
	reg do_bulk_er; // bulk erase
	wire arr_erase = do_byte_er | do_blk_er | do_bulk_er;
	wire [8:0] emask = do_bulk_er ? 9'h1ff : (do_blk_er ? 9'h07f : 9'h000);
	// mode decode; a protected latched block gets nothing at all
	always @* begin
		do_prog = 1'b0;
		do_nv_prog = 1'b0;
		do_byte_er = 1'b0;
		do_nv_er = 1'b0;
		do_blk_er = 1'b0;
		do_bulk_er = 1'b0;
		if (go && lat_nv_r) begin
			// config byte: program or byte erase only, block modes spare it
			case (ras_r)
				`MODE_PROGRAM: begin
					do_nv_prog = 1'b1;
				end
				`MODE_BYTE_ERASE: begin
					do_nv_er = 1'b1;
				end
				default: begin
					do_nv_prog = 1'b0;
				end
			endcase
		end else if (go && !blk_prot) begin
			case (ras_r)
				`MODE_PROGRAM: begin
					do_prog = 1'b1;
				end
				`MODE_BYTE_ERASE: begin
					do_byte_er = 1'b1;
				end
				`MODE_BLOCK_ERASE: begin
					do_blk_er = 1'b1;
				end
				default: begin
					do_bulk_er = ~any_prot;
				end
			endcase
		end
	end
	// wait one cycle per request so reads see registered data
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
	assign avs_response_o = resp_r;
	assign config_o = vcfg_r;
	// cell storage for the array
	nv_cell_array #(
		.DEPTH(`ARRAY_BYTES),
		.AW(9)
	) u_cells (
		.clk_sys_i(clk_sys_i),
		.raddr_i(arr_addr),
		.rdata_o(arr_rdata),
		.prog_i(do_prog),
		.erase_i(arr_erase),
		.addr_i(lat_addr_r),
		.emask_i(emask),
		.wdata_i(lat_data_r)
	);
	// internal pump driven only by program enable
	charge_pump_ctl #(
		.FALL_CYC(FALL_CYC)
	) u_pump (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.enable_i(pgm_r),
		.pump_on_o(pump_on_o),
		.hv_present_o(hv_present_o)
	);
	// read source chosen by address; latched data hides the cells
	always @* begin
		rd_mux = 8'h00;
		if (in_array && lat_r) begin
			rd_mux = lat_data_r;
		end else if (in_array) begin
			rd_mux = arr_rdata; // cell contents
		end else if (is_nv && lat_r) begin
			rd_mux = lat_data_r; // latched config target
		end else if (is_nv) begin
			rd_mux = nvcfg_r;
		end else if (is_ctrl) begin
			rd_mux = ctrl_val; // control fields, reserved bits zero
		end else if (is_vcfg) begin
			rd_mux = vcfg_r; // protection and configuration in force
		end
	end
	// bus answer: one wait cycle, then the request completes
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			resp_r <= 2'h0;
		end else begin
			ack_r <= req; // answer follows the first cycle
			if (req) begin
				resp_r <= mapped ? 2'h0 : 2'h2; // unmapped gets slave error
			end
		end
	end
	// read data register, loaded once per read and held until the next
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			avs_readdata_o <= 32'h00000000;
		end else if (req && avs_read_i) begin
			avs_readdata_o <= {24'h000000, rd_mux};
		end
	end
	// config cell: persists over reset, delivered with security bit set
	initial begin
		nvcfg_r = `NVCFG_DELIVERED;
	end
	// program/erase of the config byte, same semantics as array cells
	always @(posedge clk_sys_i) begin
		if (do_nv_er) begin
			nvcfg_r <= `ERASED_BYTE;
		end else if (do_nv_prog) begin
			nvcfg_r <= nvcfg_r & lat_data_r;
		end
	end
	// volatile config reload after reset and after each config read
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			reload_r <= 1'b1;
			vcfg_r <= 8'h00;
		end else begin
			reload_r <= req & avs_read_i & is_nv;
			if (reload_r) begin
				vcfg_r <= nvcfg_r;
			end
		end
	end
	// sequencing interlocks: enable, latch, erase select and the order flags
	always @* begin
		pgm_nxt = pgm_r;
		lat_nxt = lat_r;
		ras_nxt = ras_r;
		captured_nxt = captured_r;
		nonarray_wr_nxt = nonarray_wr_r;
		if (cap_wr) begin
			captured_nxt = 1'b1;
		end else if (ctrl_wr) begin
			// mode is frozen once enable is set
			if (!pgm_r) begin
				ras_nxt = {wbyte[`CTRL_RAS1_BIT], wbyte[`CTRL_RAS0_BIT]};
			end
			// set refused when unlatched after a non-array write
			if (wbyte[`CTRL_PGM_BIT] && !pgm_r) begin
				if (lat_r || !nonarray_wr_r) begin
					pgm_nxt = 1'b1;
				end
			end else if (!wbyte[`CTRL_PGM_BIT]) begin
				pgm_nxt = 1'b0;
			end
			// latch cannot drop while enable is or was just set
			if (pgm_r) begin
				lat_nxt = 1'b1;
			end else begin
				lat_nxt = wbyte[`CTRL_LAT_BIT]; // latch follows the write
				if (!wbyte[`CTRL_LAT_BIT]) begin
					captured_nxt = 1'b0; // dropping the latch forgets the capture
				end else if (!lat_r) begin
					captured_nxt = 1'b0; // a fresh latch needs a fresh write
					nonarray_wr_nxt = 1'b0; // a fresh latch restarts the order
				end
			end
		end else if (stray_wr) begin
			nonarray_wr_nxt = 1'b1;
		end
	end
	// sequencing state registers
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			pgm_r <= 1'b0;
			lat_r <= 1'b0;
			ras_r <= 2'h0;
			captured_r <= 1'b0;
			nonarray_wr_r <= 1'b0;
			pgm_d_r <= 1'b0;
		end else begin
			pgm_r <= pgm_nxt;
			lat_r <= lat_nxt;
			ras_r <= ras_nxt;
			captured_r <= captured_nxt;
			nonarray_wr_r <= nonarray_wr_nxt;
			pgm_d_r <= pgm_r; // edge detect for the operation pulse
		end
	end
	// power-down and pump clock bits are stored for software only
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			off_r <= 1'b0;
			bclk_r <= 1'b0;
		end else if (ctrl_wr) begin
			off_r <= wbyte[`CTRL_OFF_BIT];
			bclk_r <= wbyte[`CTRL_BCLK_BIT];
		end
	end
	// address and data latch; the latest valid write replaces the capture
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			lat_addr_r <= 9'h000;
			lat_data_r <= 8'h00;
			lat_nv_r <= 1'b0;
		end else if (cap_wr) begin
			lat_addr_r <= arr_addr;
			lat_data_r <= wbyte;
			lat_nv_r <= is_nv; // config byte as target
		end
	end
endmodule // nv_array_ctrl
`default_nettype wire

/* File: common/nv_array_consts.vh */
// constants for the nonvolatile array program/erase controller
`ifndef NV_ARRAY_CONSTS_VH
`define NV_ARRAY_CONSTS_VH
// byte addresses on the avalon bus (one byte per address, array index is the low nine bits)
`define ARRAY_BASE_IDX 12'h800
`define ARRAY_LAST_IDX 12'h9ff
`define NVCFG_IDX 12'he1c
`define CTRL_IDX 12'he1d
`define VCFG_IDX 12'he1f
`define ARRAY_BYTES 512
`define BLOCK_BYTES 128
// control register fields
`define CTRL_PGM_BIT 0
`define CTRL_LAT_BIT 2
`define CTRL_RAS0_BIT 3
`define CTRL_RAS1_BIT 4
`define CTRL_OFF_BIT 5
`define CTRL_BCLK_BIT 7
`define CTRL_WMASK 8'hbd
// erase select encodings
`define MODE_PROGRAM 2'h0
`define MODE_BYTE_ERASE 2'h1
`define MODE_BLOCK_ERASE 2'h2
`define MODE_BULK_ERASE 2'h3
// delivered content
`define ERASED_BYTE 8'hff
`define NVCFG_DELIVERED 8'h10
`define NV_SECURITY_BIT 4
`endif

/* File: rtl/nv_cell_array.v */
// nonvolatile byte array with program-only-clears and erase-sets semantics
`include "nv_array_consts.vh"
`default_nettype none
module nv_cell_array #(
	parameter DEPTH = 512, // bytes held
	parameter AW = 9 // address width
) (
	input wire clk_sys_i, // system clock
	input wire [AW-1:0] raddr_i, // read address
	output wire [7:0] rdata_o, // read data
	input wire prog_i, // program pulse: and data into cell
	input wire erase_i, // erase pulse over masked range
	input wire [AW-1:0] addr_i, // target address
	input wire [AW-1:0] emask_i, // address bits ignored during erase
	input wire [7:0] wdata_i // program data
);
	// cells survive reset; the delivered state is all ones
	reg [7:0] cell_r [0:DEPTH-1];
	integer i; // cell index of the clocked update
	integer j; // cell index of the delivered content
	// initial content models delivery erased
	initial begin
		for (j = 0; j < DEPTH; j = j + 1) begin
			cell_r[j] = `ERASED_BYTE;
		end
	end
	// program clears bits only, erase returns them to one
	always @(posedge clk_sys_i) begin
		for (i = 0; i < DEPTH; i = i + 1) begin
			if (erase_i && ((i[AW-1:0] | emask_i) == (addr_i | emask_i))) begin
				cell_r[i] <= `ERASED_BYTE;
			end else if (prog_i && i[AW-1:0] == addr_i) begin
				cell_r[i] <= cell_r[i] & wdata_i;
			end
		end
	end
	assign rdata_o = cell_r[raddr_i];
endmodule // nv_cell_array
`default_nettype wire

/* File: rtl/charge_pump_ctl.v */
// charge pump enable and high-voltage presence model
`default_nettype none
module charge_pump_ctl #(
	parameter FALL_CYC = 4 // cycles the high voltage takes to decay
) (
	input wire clk_sys_i, // system clock
	input wire rst_i, // synchronous reset
	input wire enable_i, // pump request
	output reg pump_on_o, // pump running
	output wire hv_present_o // high voltage still on the array
);
	reg [7:0] fall_r; // decay counter
	// pump follows the request; voltage lingers after stop
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			pump_on_o <= 1'b0;
			fall_r <= 8'h00;
		end else begin
			pump_on_o <= enable_i;
			if (enable_i) begin
				fall_r <= FALL_CYC[7:0];
			end else if (fall_r != 8'h00) begin
				fall_r <= fall_r - 8'h01;
			end
		end
	end
	assign hv_present_o = pump_on_o | (fall_r != 8'h00);
endmodule // charge_pump_ctl
`default_nettype wire

/* File: verification/nv_array_ctrl_chk.sv */
// port assertions for the array controller
`default_nettype none
module nv_array_ctrl_chk #(
	parameter int FALL_CYC = 4 // decay cycles
) (
	input wire logic clk_sys_i, // clock
	input wire logic rst_i, // reset
	input wire logic [11:0] avs_address_i, // address
	input wire logic avs_read_i, // read
	input wire logic avs_write_i, // write
	input wire logic [31:0] avs_readdata_o, // read data
	input wire logic avs_waitrequest_o, // wait
	input wire logic [1:0] avs_response_o, // response
	input wire logic pump_on_o, // pump
	input wire logic hv_present_o, // high voltage
	input wire logic [7:0] config_o // volatile config
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	wire logic req = avs_read_i | avs_write_i; // request open
	wire logic done = req & ~avs_waitrequest_o; // answer cycle
	wire logic hit = avs_address_i[11:9] == 3'h4 || avs_address_i inside {12'he1c, 12'he1d, 12'he1f}; // mapped
	wire logic cfg_rd = done & avs_read_i & (avs_address_i == 12'he1c); // config read
	wire logic ctl_wr = done & avs_write_i & (avs_address_i == 12'he1d); // control write
	a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest_o) else $error("no wait");
	a_wait_answer: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("slow");
	a_resp_err: assert property (done && !hit |=> avs_response_o == 2'h2) else $error("no error");
	a_resp_ok: assert property (done && hit |=> avs_response_o == 2'h0) else $error("bad resp");
	a_rd_upper: assert property (done && avs_read_i |-> avs_readdata_o[31:8] == 24'h0) else $error("upper");
	a_hv_bounded: assert property (!pump_on_o [*6] |-> !hv_present_o) else $error("voltage lingers");
	a_hv_fall: assert property ($fell(pump_on_o) |-> hv_present_o ##[1:8] !hv_present_o)
		else $error("hv stuck");
	a_pump_cause: assert property ($rose(pump_on_o) |-> $past(ctl_wr) || $past(ctl_wr, 2) || $past(ctl_wr, 3))
		else $error("pump uncaused");
	a_cfg_cause: assert property ($changed(config_o) |-> $past(rst_i) || $past(rst_i, 2) || $past(cfg_rd)
		|| $past(cfg_rd, 2) || $past(cfg_rd, 3)) else $error("config moved");
	cover property ($rose(pump_on_o));
	cover property (done && !hit);
	cover property (cfg_rd);
endmodule // nv_array_ctrl_chk
bind nv_array_ctrl nv_array_ctrl_chk #(.FALL_CYC(FALL_CYC)) u_chk (.clk_sys_i, .rst_i, .avs_address_i,
	.avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .avs_response_o, .pump_on_o,
	.hv_present_o, .config_o);
`default_nettype wire

/* File: verification/nv_host.sv */
// bus master standing for the processor
`default_nettype none
module nv_host (
	input wire logic clk_sys_i, // clock
	output logic [11:0] adr_o, // address
	output logic rd_o, // read strobe
	output logic wr_o, // write strobe
	output logic [31:0] wd_o, // write data
	input wire logic [31:0] rdat_i, // read data
	input wire logic wait_i, // wait request
	output logic tmo_o // answer never came
);
	timeunit 1ns;
	timeprecision 100ps;
	int n;
	// idle bus from time zero
	initial begin
		{adr_o, rd_o, wr_o, wd_o, tmo_o} = '0;
	end
	// one transfer, held until wait is low at an edge
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_sys_i);
		adr_o <= a;
		wr_o <= w;
		rd_o <= !w;
		wd_o <= {24'h0, d};
		n = 0;
		// wait and read data are taken at the same rising edge
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (wait_i !== 1'b0 && n < 50);
		tmo_o = wait_i !== 1'b0;
		q = rdat_i[7:0];
		rd_o <= 1'b0;
		wr_o <= 1'b0;
	endtask
endmodule // nv_host
`default_nettype wire

/* File: verification/nv_array_ctrl_tb.sv */
// self-checking bench for the array controller
`default_nettype none
module nv_array_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys_i = 0, rst_i = 1, rd, wr, wt, tmo, pump, hv;
	logic [11:0] adr;
	logic [31:0] wd, rdat;
	logic [1:0] resp;
	logic [7:0] cfg, q, nvcfg = 8'h10, mem [512];
	int fail_count = 0, num_checks = 0, seed = 93, i;
	nv_array_ctrl #(.FALL_CYC(4)) u_nv_array_ctrl (.clk_sys_i, .rst_i, .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'h1), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wt), .avs_response_o(resp), .pump_on_o(pump), .hv_present_o(hv), .config_o(cfg));
	nv_host host (.clk_sys_i, .adr_o(adr), .rd_o(rd), .wr_o(wr), .wd_o(wd), .rdat_i(rdat), .wait_i(wt), .tmo_o(tmo));
	// free running clock
	initial begin
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	// compare seen against expected
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// one bus access, a hang ends the run
	task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
		host.xfer(w, a, d, q);
		if (tmo) begin
			fail_count++;
			tally_and_finish;
		end
	endtask
	// full program or erase sequence plus model update
	task automatic pe(input logic [1:0] m, input logic [11:0] a, input logic [7:0] d);
		logic [7:0] lc;
		lc = {3'h0, m, 3'h4};
		acc(1, 12'he1d, lc);
		acc(1, 12'he1d, lc | 8'h1);
		acc(0, 12'he1d, 0);
		check(q, lc);
		if (a[11:9] == 3'h4) acc(1, a ^ 12'h1, ~d);
		acc(1, a, d);
		if (a[11:9] == 3'h4) begin
			acc(0, a ^ 12'h40, 0);
			check(q, d);
		end
		acc(1, 12'he1d, lc | 8'h1);
		acc(1, 12'he1d, {3'h0, ~m, 3'h5});
		acc(0, 12'he1d, 0);
		check(q, lc | 8'h1);
		check(pump, 1);
		acc(1, 12'he1d, {3'h0, m, 3'h0});
		acc(0, 12'he1d, 0);
		check(q, lc);
		check(pump, 0);
		acc(1, 12'he1d, 0);
		if (a == 12'he1c) begin
			if (m < 2) nvcfg = m ? 8'hff : nvcfg & d;
		end else if (!nvcfg[a[8:7]]) begin
			case (m)
				0: mem[a[8:0]] &= d;
				1: mem[a[8:0]] = 8'hff;
				2: for (int k = 0; k < 128; k++) mem[{a[8:7], k[6:0]}] = 8'hff;
				3: if (nvcfg[3:0] == 0) foreach (mem[k]) mem[k] = 8'hff;
			endcase
		end
		acc(0, a, 0);
		check(q, a == 12'he1c ? nvcfg : mem[a[8:0]]);
		if (a[11:9] == 3'h4) begin
			acc(0, {a[11:7], 7'h0}, 0);
			check(q, mem[{a[8:7], 7'h0}]);
		end
	endtask
	// main sequence
	initial begin
		foreach (mem[k]) mem[k] = 8'hff;
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 0;
		acc(0, 12'h800, 0);
		check(q, 8'hff);
		check(cfg, 8'h10);
		for (i = 0; i < 10; i++) pe(i < 2 ? 2'h0 : 2'(i), i < 2 ? 12'h805 : {3'h4, 9'($random(seed))}, 8'($random(seed)));
		acc(1, 12'he1e, 8'h0);
		check(resp, 2'h2);
		acc(1, 12'he1d, 8'h01);
		acc(0, 12'he1d, 0);
		check(q, 8'h00);
		check(pump, 0);
		pe(2'h1, 12'he1c, 8'h0);
		acc(0, 12'he1e, 0);
		check(resp, 2'h2);
		check(cfg, 8'hff);
		pe(2'h0, 12'h805, 8'h0);
		pe(2'h3, 12'h900, 8'h0);
		tally_and_finish;
	end
endmodule // nv_array_ctrl_tb
`default_nettype wire
